// >>> design/alu_branch_core.sv
// alu and branch execution subset behind an apb register port
//
// The register offsets and register access over APB were chosen for this implementation.
`include "alu_map.svh"
module alu_branch_core
  import alu_pkg::*;
#(
  parameter int DW = 16  // data word width
)
(
  input  wire logic        pclk,     // core clock
  input  wire logic        presetn,  // async reset, active low
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb access phase
  input  wire logic        pwrite,   // apb direction
  input  wire logic [11:0] paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  output logic      [31:0] prdata,   // apb read data
  output logic             pready,   // apb ready
  output logic             pslverr,  // apb error
  output logic             busy      // instruction in progress
);
  op_t          op;
  cond_t        cond;
  logic [4:0]   shamt;
  logic         acc_sel;
  logic         periph;
  logic [DW-1:0] opa;
  logic [DW-1:0] opb;
  logic [DW-1:0] result;
  logic [`ACC_W-1:0] acc_a;
  logic [`ACC_W-1:0] acc_b;
  flags_t       fl;
  state_t       state;
  logic [2:0]   cyc_left;
  logic         taken_r;
  logic         taken;
  logic         wr_go;
  logic         map_ok;
  logic [2:0]   next_cycles;
  logic [2:0]   extra;

  branch_eval u_branch (
    .cond  (cond),
    .fl    (fl),
    .taken (taken)
  );

  // apb: always ready, writes land in the access phase
  assign pready  = 1'b1;
  assign wr_go   = psel & penable & pwrite & (paddr == `ADDR_CTRL)
                 & pwdata[`CTRL_GO_BIT] & (state == st_idle);
  assign busy    = (state == st_busy);

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `ADDR_CTRL) || (a == `ADDR_OPA) || (a == `ADDR_OPB)
          || (a == `ADDR_RESULT) || (a == `ADDR_FLAGS)
          || (a == `ADDR_ACCA_LO) || (a == `ADDR_ACCA_HI)
          || (a == `ADDR_ACCB_LO) || (a == `ADDR_ACCB_HI)
          || (a == `ADDR_STATUS);
  endfunction
  assign map_ok  = mapped(paddr);
  assign pslverr = psel & penable & ~map_ok;

  // cycle cost of the launched instruction
  always_comb
  begin
    case (op)
      op_branch_cond:     next_cycles = taken ? `CYC_TAKEN : `CYC_ONE;
      op_branch_always,
      op_branch_computed: next_cycles = `CYC_TAKEN;
      // one cycle, one more on a peripheral register
      default:            next_cycles = `CYC_ONE + {2'b00, periph};
    endcase
  end

  // control and operand registers written by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op      <= op_add_with_carry;
      cond    <= c_c;
      shamt   <= 5'h00;
      acc_sel <= 1'b0;
      periph  <= 1'b0;
      opa     <= '0;
      opb     <= '0;
    end
    else if (psel && penable && pwrite && state == st_idle)
    begin
      case (paddr)
        `ADDR_CTRL:
        begin
          op      <= op_t'(pwdata[`CTRL_OP_LSB +: 4]);
          cond    <= cond_t'(pwdata[`CTRL_COND_LSB +: 5]);
          shamt   <= pwdata[`CTRL_SHIFT_LSB +: 5];
          acc_sel <= pwdata[`CTRL_ACC_BIT];
          periph  <= pwdata[`CTRL_PERIPH_BIT];
        end
        `ADDR_OPA: opa <= pwdata[DW-1:0];
        `ADDR_OPB: opb <= pwdata[DW-1:0];
        default: ;
      endcase
    end
  end

  // sequencer: counts the instruction's cycles, plus one for peripheral access on non-branch ops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state    <= st_idle;
      cyc_left <= 3'd0;
    end
    else
    begin
      case (state)
        st_idle:
          if (wr_go)
          begin
            state    <= st_busy;
            cyc_left <= 3'd0;
          end
        st_busy:
          // execute cycle loads the cycles still owed after it
          if (cyc_left == 3'd0 && taken_r == 1'b0)
          begin
            if (extra == 3'd0)
              state <= st_idle;
            else
              cyc_left <= extra;
          end
          else if (cyc_left <= 3'd1)
          begin
            state    <= st_idle;
            cyc_left <= 3'd0;
          end
          else
            cyc_left <= cyc_left - 3'd1;
        default: state <= st_idle;
      endcase
    end
  end

  // execution: results and flags settle in the first busy cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    logic [DW:0]       sum;
    logic [4:0]        lo;
    logic [DW-1:0]     r;
    logic [`ACC_W-1:0] ext;
    logic [`ACC_W:0]   asum;
    logic [`ACC_W-1:0] acc_cur;
    logic              ovf;
    logic [3:0]        slit;
    if (!presetn)
    begin
      result  <= '0;
      fl      <= '0;
      acc_a   <= '0;
      acc_b   <= '0;
      taken_r <= 1'b0;
    end
    else if (state == st_busy && cyc_left == 3'd0 && !taken_r)
    begin
      sum     = '0;
      lo      = '0;
      r       = '0;
      ext     = '0;
      asum    = '0;
      ovf     = 1'b0;
      slit    = shamt[3:0];
      acc_cur = acc_sel ? acc_b : acc_a;
      case (op)
        op_add_with_carry:
        begin
          sum = {1'b0, opa} + {1'b0, opb} + {{DW{1'b0}}, fl.c};
          lo  = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, fl.c};
          r   = sum[DW-1:0];
          result <= r;
          fl.c   <= sum[DW];
          fl.dc  <= lo[4];
          fl.ov  <= (opa[DW-1] == opb[DW-1]) && (r[DW-1] != opa[DW-1]);
          fl.n   <= r[DW-1];
          fl.z   <= (r == '0);
        end
        op_acc_add:
        begin
          // signed literal: positive shifts right, negative shifts left
          ext = {{(`ACC_W-DW){opa[DW-1]}}, opa};
          if (slit[3])
            ext = ext << (5'd16 - {1'b0, slit});
          else
            ext = $signed(ext) >>> slit;
          asum = {acc_cur[`ACC_W-1], acc_cur} + {ext[`ACC_W-1], ext};
          ovf  = asum[`ACC_W] != asum[`ACC_W-1];
          // saturate rather than wrap on a 40-bit overflow
          if (ovf)
            asum[`ACC_W-1:0] = asum[`ACC_W] ? `ACC_MIN : `ACC_MAX;
          if (acc_sel)
          begin
            acc_b <= asum[`ACC_W-1:0];
            fl.ob <= ovf;
            fl.sb <= fl.sb | ovf;      // sticky until reset
          end
          else
          begin
            acc_a <= asum[`ACC_W-1:0];
            fl.oa <= ovf;
            fl.sa <= fl.sa | ovf;
          end
        end
        op_asr_one:
        begin
          r = {opa[DW-1], opa[DW-1:1]};
          result <= r;
          fl.c   <= opa[0];
          fl.ov  <= 1'b0;
          fl.n   <= r[DW-1];
          fl.z   <= (r == '0);
        end
        op_asr_count:
        begin
          r = $signed(opa) >>> shamt[3:0];
          result <= r;
          fl.n   <= r[DW-1];
          fl.z   <= (r == '0);
        end
        op_branch_computed: result <= opa;  // target word
        default: ;
      endcase
      // extra cycle for peripheral register access on non-branch ops; taken branch adds three
      taken_r <= 1'b1;
    end
    else if (state == st_idle)
      taken_r <= 1'b0;
  end

  // cycles still owed after the execute cycle
  assign extra = next_cycles - `CYC_ONE;

  // read mux, registered data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `ADDR_CTRL:    prdata <= {27'h0, 1'b0, op};
        `ADDR_OPA:     prdata <= {{(32-DW){1'b0}}, opa};
        `ADDR_OPB:     prdata <= {{(32-DW){1'b0}}, opb};
        `ADDR_RESULT:  prdata <= {{(32-DW){1'b0}}, result};
        `ADDR_FLAGS:   prdata <= {23'h0, fl};
        `ADDR_ACCA_LO: prdata <= acc_a[31:0];
        `ADDR_ACCA_HI: prdata <= {24'h0, acc_a[`ACC_W-1:32]};
        `ADDR_ACCB_LO: prdata <= acc_b[31:0];
        `ADDR_ACCB_HI: prdata <= {24'h0, acc_b[`ACC_W-1:32]};
        `ADDR_STATUS:  prdata <= {29'h0, cyc_left[1:0], busy};
        default:       prdata <= 32'h0;
      endcase
    end
  end
endmodule

// >>> design/alu_map.svh
// constants for the alu and branch execution block
`ifndef ALU_MAP_SVH
`define ALU_MAP_SVH
`define ADDR_CTRL      12'h000
`define ADDR_OPA       12'h004
`define ADDR_OPB       12'h008
`define ADDR_RESULT    12'h00c
`define ADDR_FLAGS     12'h010
`define ADDR_ACCA_LO   12'h014
`define ADDR_ACCA_HI   12'h018
`define ADDR_ACCB_LO   12'h01c
`define ADDR_ACCB_HI   12'h020
`define ADDR_STATUS    12'h024
`define CTRL_GO_BIT    31
`define CTRL_OP_LSB    0
`define CTRL_COND_LSB  8
`define CTRL_SHIFT_LSB 16
`define CTRL_ACC_BIT   24
`define CTRL_PERIPH_BIT 25
`define FLAG_C         0
`define FLAG_DC        1
`define FLAG_N         2
`define FLAG_OV        3
`define FLAG_Z         4
`define FLAG_OA        5
`define FLAG_OB        6
`define FLAG_SA        7
`define FLAG_SB        8
`define CYC_ONE        3'd1
`define CYC_TAKEN      3'd4
`define ACC_W          40
`define ACC_MAX        40'h7fffffffff
`define ACC_MIN        40'h8000000000
`endif

// >>> design/alu_pkg.sv
// types shared by the alu and branch execution block
package alu_pkg;
  typedef enum logic [3:0] {
    op_add_with_carry = 4'h0,
    op_acc_add        = 4'h1,
    op_asr_one        = 4'h2,
    op_asr_count      = 4'h3,
    op_branch_cond    = 4'h4,
    op_branch_always  = 4'h5,
    op_branch_computed = 4'h6
  } op_t;
  typedef enum logic [4:0] {
    c_c = 5'h00, c_ge = 5'h01, c_geu = 5'h02, c_gt = 5'h03,
    c_gtu = 5'h04, c_le = 5'h05, c_leu = 5'h06, c_lt = 5'h07,
    c_ltu = 5'h08, c_n = 5'h09, c_nc = 5'h0a, c_nn = 5'h0b,
    c_nov = 5'h0c, c_nz = 5'h0d, c_oa = 5'h0e, c_ob = 5'h0f,
    c_ov = 5'h10, c_sa = 5'h11, c_sb = 5'h12, c_z = 5'h13
  } cond_t;
  typedef struct packed {
    logic sb, sa, ob, oa, z, ov, n, dc, c;
  } flags_t;
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_busy = 2'b10
  } state_t;
endpackage

// >>> design/branch_eval.sv
// branch condition evaluation from the status flags
`include "alu_map.svh"
module branch_eval
  import alu_pkg::*;
(
  input  wire cond_t  cond,   // condition selector
  input  wire flags_t fl,     // current flags
  output logic        taken   // condition holds
);
  // signed compare uses n xor ov, unsigned uses carry as not-borrow
  always_comb
  begin
    case (cond)
      c_c:   taken = fl.c;
      c_ge:  taken = ~(fl.n ^ fl.ov);
      c_geu: taken = fl.c;
      c_gt:  taken = ~fl.z & ~(fl.n ^ fl.ov);
      c_gtu: taken = fl.c & ~fl.z;
      c_le:  taken = fl.z | (fl.n ^ fl.ov);
      c_leu: taken = ~fl.c | fl.z;
      c_lt:  taken = fl.n ^ fl.ov;
      c_ltu: taken = ~fl.c;
      c_n:   taken = fl.n;
      c_nc:  taken = ~fl.c;
      c_nn:  taken = ~fl.n;
      c_nov: taken = ~fl.ov;
      c_nz:  taken = ~fl.z;
      c_oa:  taken = fl.oa;
      c_ob:  taken = fl.ob;
      c_ov:  taken = fl.ov;
      c_sa:  taken = fl.sa;
      c_sb:  taken = fl.sb;
      c_z:   taken = fl.z;
      default: taken = 1'b0;
    endcase
  end
endmodule

// >>> dv/alu_branch_core_checker.sv
// port checks for the alu and branch core
module alu_branch_core_checker
(
  input wire logic        pclk,     // core clock
  input wire logic        presetn,  // reset, active low
  input wire logic        psel,     // apb select
  input wire logic        penable,  // apb access
  input wire logic        pwrite,   // apb direction
  input wire logic [11:0] paddr,    // apb address
  input wire logic [31:0] pwdata,   // apb write data
  input wire logic [31:0] prdata,   // apb read data
  input wire logic        pready,   // apb ready
  input wire logic        pslverr,  // apb error
  input wire logic        busy      // instruction running
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic       go;  // accepted start, refused while busy
  logic [3:0] op;  // operation field
  logic       pe;  // peripheral register access
  // decode of a start write
  assign go = psel & penable & pwrite & (paddr == 12'h000)
            & pwdata[31] & !busy;
  assign op = pwdata[3:0];
  assign pe = pwdata[25];
  a_ready_high: assert property (pready)
    else $error("pready dropped");
  a_err_unmapped: assert property (psel && penable && paddr > 12'h024
    |-> pslverr) else $error("no error on unmapped address");
  a_err_mapped: assert property (psel && penable && paddr[1:0] == 2'h0
    && paddr <= 12'h024 |-> !pslverr) else $error("error on mapped word");
  a_busy_start: assert property (go |=> busy)
    else $error("start not seen");
  a_busy_cause: assert property (!busy && !go |=> !busy)
    else $error("busy without start");
  a_single_cycle: assert property (go && op < 4'h4 && !pe
    |=> busy ##1 !busy) else $error("one cycle op wrong length");
  a_branch_fixed: assert property (go && op inside {4'h5, 4'h6}
    |=> busy[*4] ##1 !busy) else $error("branch not four cycles");
  a_branch_cond: assert property (go && op == 4'h4 && !pe
    |=> (busy ##1 !busy) or (busy[*4] ##1 !busy))
    else $error("conditional branch wrong length");
  a_periph_extra: assert property (go && op inside {4'h0, 4'h2, 4'h3}
    && pe |=> busy[*2] ##1 !busy) else $error("no extra cycle");
endmodule
bind alu_branch_core alu_branch_core_checker alu_branch_core_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .busy(busy));

// >>> dv/testbench.sv
// self-checking bench for the alu and branch core
module testbench import alu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
  logic        err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          mismatches, checked, k;
  alu_branch_core alu_branch_core_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy));
  // 8 ns clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // one apb transfer, held until pready is seen high
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  function logic [31:0] mk(input logic [3:0] op, input logic [4:0] cd,
                           input logic [4:0] sh, input logic ac, pe);
    return {1'b1, 5'h00, pe, ac, 3'h0, sh, 3'h0, cd, 4'h0, op};
  endfunction
  // start an op and count busy cycles, sampled mid-cycle
  task run(input logic [31:0] a, input logic [31:0] c, input int cyc);
    int n;
    n = 0;
    xfer(1'b1, 12'h004, a);
    xfer(1'b1, 12'h000, c);
    @(negedge pclk);
    while (busy === 1'b1 && n < 20)
    begin
      n++;
      @(negedge pclk);
    end
    chk("busy cycles", n, cyc);
  endtask
  task flg(input logic [8:0] f);
    xfer(1'b0, 12'h010, 32'h0);
    chk("flags", rd, {23'h0, f});
  endtask
  task res(input logic [15:0] r, input logic [8:0] f);
    xfer(1'b0, 12'h00c, 32'h0);
    chk("result", rd, {16'h0, r});
    flg(f);
  endtask
  // branch outcome for flags c=1 n=1, all others clear
  function logic tk(input int i);
    return i inside {0, 2, 4, 5, 7, 9, 12, 13};
  endfunction
  task final_report();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    final_report();
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // carry chain: overflow, carry out, then carry in used
    xfer(1'b1, 12'h008, 32'h1);
    run(32'h7fff, mk(op_add_with_carry, 0, 0, 0, 0), 1);
    res(16'h8000, 9'h00e);
    run(32'h0004, mk(op_asr_count, 0, 3, 0, 0), 1);
    res(16'h0000, 9'h01a);
    run(32'hffff, mk(op_add_with_carry, 0, 0, 0, 0), 1);
    res(16'h0000, 9'h013);
    run(32'h0001, mk(op_add_with_carry, 0, 0, 0, 0), 1);
    res(16'h0003, 9'h000);
    run(32'h8001, mk(op_asr_one, 0, 0, 0, 0), 1);
    res(16'hc000, 9'h005);
    $display("test arithmetic done");
    // every condition, taken costs four cycles
    for (k = 0; k < 20; k++)
      run(32'h0, mk(op_branch_cond, k[4:0], 0, 0, 0), tk(k) ? 4 : 1);
    run(32'h0, mk(op_branch_always, 0, 0, 0, 0), 4);
    run(32'h0, mk(op_branch_computed, 0, 0, 0, 0), 4);
    flg(9'h005);
    $display("test branches done");
    // accumulator adds: sign extension and a right shift
    run(32'h8000, mk(op_acc_add, 0, 0, 0, 0), 1);
    xfer(1'b0, 12'h014, 32'h0);
    chk("acc a low", rd, 32'hffff8000);
    xfer(1'b0, 12'h018, 32'h0);
    chk("acc a high", rd, 32'h000000ff);
    run(32'h0100, mk(op_acc_add, 0, 5'h04, 1, 0), 1);
    xfer(1'b0, 12'h01c, 32'h0);
    chk("acc b low", rd, 32'h00000010);
    flg(9'h005);
    run(32'h0, mk(op_branch_cond, c_sa, 0, 0, 0), 1);
    $display("test accumulators done");
    // peripheral access costs one more cycle, but none on an always branch
    run(32'h8001, mk(op_asr_one, 0, 0, 0, 1), 2);
    run(32'h0, mk(op_branch_always, 0, 0, 0, 1), 4);
    xfer(1'b0, 12'h028, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    xfer(1'b0, 12'h024, 32'h0);
    chk("mapped error", {31'h0, err}, 32'h0);
    chk("status idle", rd, 32'h0);
    $display("test access done");
    final_report();
  end
endmodule
